// ### supply_wd_defs.svh
`ifndef SUPPLY_WD_DEFS_SVH
`define SUPPLY_WD_DEFS_SVH

// ----------------------------------------
// Clock and time base
// ----------------------------------------
`define CLK_PERIOD_NS 50
`define TICK_NS       250000
`define TICK_US       250
`define TICK_CYC_DFLT (`TICK_NS / `CLK_PERIOD_NS)
`define PRE_W         13

// ----------------------------------------
// Durations in their own units
// ----------------------------------------
`define WD_P0_US      750
`define WD_P1_US      1500
`define WD_P2_US      12500
`define WD_P3_US      25000
`define HOLD1_MS      50
`define HOLD2_MS      10
`define US_PER_MS     1000

// Least times round up to whole ticks.
`define US_TICKS(t)   (((t) + `TICK_US - 1) / `TICK_US)
`define MS_TICKS(t)   `US_TICKS((t) * `US_PER_MS)

// ----------------------------------------
// Counters and input bundle
// ----------------------------------------
`define CNT_W         8
`define IN_W          5
`define IN_UV         0
`define IN_KICK       1
`define IN_SEL_LO     2
`define IN_SEL_HI     3
`define IN_FLOAT      4
`define IN_RST        5'h01
`define HELP_W        24

`endif

// ### supply_wd_pkg.sv
`default_nettype none
`include "supply_wd_defs.svh"

package supply_wd_pkg;
  // Reset sequence: both low, secondary only low, running.
  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_EXT  = 3'b010,
    ST_RUN  = 3'b100
  } seq_state_e;

  typedef logic [`CNT_W-1:0] tick_count_t;
endpackage

`default_nettype wire

// ### supply_watchdog_reset_gen.sv
`timescale 1ns/1ns
`default_nettype none
`include "supply_wd_defs.svh"

module supply_watchdog_reset_gen #(
  parameter int TICK_CYCLES = `TICK_CYC_DFLT
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic monitored_supply_low,
  input  wire logic kick_input,
  input  wire logic kick_floating,
  input  wire logic period_sel_hi,
  input  wire logic period_sel_lo,
  output var  logic reset1_n,
  output var  logic reset2_n
);
  import supply_wd_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Watchdog period in ticks for a select code, high bit first.
  function automatic tick_count_t period_ticks(input logic [1:0] sel);
    tick_count_t p;
    p = tick_count_t'(`US_TICKS(`WD_P0_US));
    unique case (sel)
      2'h0: p = tick_count_t'(`US_TICKS(`WD_P0_US));
      2'h1: p = tick_count_t'(`US_TICKS(`WD_P1_US));
      2'h2: p = tick_count_t'(`US_TICKS(`WD_P2_US));
      2'h3: p = tick_count_t'(`US_TICKS(`WD_P3_US));
    endcase
    return p;
  endfunction

  localparam tick_count_t HOLD1_TICKS = tick_count_t'(`MS_TICKS(`HOLD1_MS));
  localparam tick_count_t HOLD2_TICKS = tick_count_t'(`MS_TICKS(`HOLD2_MS));
  localparam logic [`PRE_W-1:0] PRE_LAST = `PRE_W'(TICK_CYCLES - 1);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [`IN_W-1:0] sync1;
  logic [`IN_W-1:0] sync2;
  logic [`IN_W-1:0] sync3;
  logic [`IN_W-1:0] filt;
  logic [`IN_W-1:0] raw;
  logic [`IN_W-1:0] agree;
  logic [`IN_W-1:0] next_filt;

  assign raw = {kick_floating, period_sel_hi, period_sel_lo,
                kick_input, monitored_supply_low};

  // A bit only moves once stages two and three agree, which rejects a
  // single-cycle glitch on a pin at the cost of two cycles of latency.
  always_comb begin
    agree     = ~(sync2 ^ sync3);
    next_filt = (sync2 & agree) | (filt & ~agree);
  end

  // The filtered supply flag starts high so power-up begins a sequence.
  // The stages start at the same value as the filter, so no bit can
  // flip on the first edge before the real pin level has arrived.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1 <= `IN_RST;
      sync2 <= `IN_RST;
      sync3 <= `IN_RST;
      filt  <= `IN_RST;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
      sync3 <= sync2;
      filt  <= next_filt;
    end
  end

  logic       uv;
  logic       wd_off;
  logic [1:0] sel;
  logic       kick_edge;

  assign uv        = filt[`IN_UV];
  assign wd_off    = filt[`IN_FLOAT];
  assign sel       = {filt[`IN_SEL_HI], filt[`IN_SEL_LO]};
  assign kick_edge = next_filt[`IN_KICK] != filt[`IN_KICK];

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  seq_state_e        state;
  seq_state_e        next_state;
  logic [`PRE_W-1:0] pre;
  logic [`PRE_W-1:0] next_pre;
  tick_count_t       cnt;
  tick_count_t       next_cnt;
  tick_count_t       ext;
  tick_count_t       next_ext;
  logic              tick;
  logic              wd_expire;
  logic              next_r1n;
  logic              next_r2n;

  // Hold and watchdog share one prescaler; it is cleared at each
  // sequence start so both hold times are exact to the cycle.
  always_comb begin
    tick       = pre == PRE_LAST;
    next_pre   = tick ? '0 : pre + 1'b1;
    next_state = state;
    next_cnt   = cnt;
    next_ext   = ext;
    wd_expire  = 1'b0;
    if (uv) begin
      next_state = ST_HOLD;
      next_cnt   = '0;
      next_pre   = '0;
    end else begin
      unique case (state)
        ST_HOLD: begin
          if (tick) begin
            next_cnt = cnt + 1'b1;
            if (cnt + 1'b1 == HOLD1_TICKS) begin
              next_state = ST_EXT;
              next_cnt   = '0;
              next_ext   = '0;
            end
          end
        end
        ST_EXT, ST_RUN: begin
          if (kick_edge) begin
            next_cnt = '0;
          end else if (tick && !wd_off) begin
            next_cnt  = cnt + 1'b1;
            // At or past the period, so a shorter period picked mid-count
            // still expires instead of waiting for the counter to wrap.
            wd_expire = cnt + 1'b1 >= period_ticks(sel);
          end
          if (state == ST_EXT && tick) begin
            next_ext = ext + 1'b1;
            if (ext + 1'b1 == HOLD2_TICKS) begin
              next_state = ST_RUN;
            end
          end
          if (wd_expire) begin
            next_state = ST_HOLD;
            next_cnt   = '0;
            next_pre   = '0;
          end
        end
      endcase
    end
    // Outputs follow the next state so they change with it.
    next_r1n = next_state != ST_HOLD;
    next_r2n = next_state == ST_RUN;
  end

  // Power-up reset holds both outputs asserted.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state    <= ST_HOLD;
      pre      <= '0;
      cnt      <= '0;
      ext      <= '0;
      reset1_n <= 1'b0;
      reset2_n <= 1'b0;
    end else begin
      state    <= next_state;
      pre      <= next_pre;
      cnt      <= next_cnt;
      ext      <= next_ext;
      reset1_n <= next_r1n;
      reset2_n <= next_r2n;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  localparam int HOLD1_CYC = int'(HOLD1_TICKS) * TICK_CYCLES;
  localparam int HOLD2_CYC = int'(HOLD2_TICKS) * TICK_CYCLES;

  logic [`HELP_W-1:0] low_cyc;
  logic [`HELP_W-1:0] ext_cyc;
  logic [`HELP_W-1:0] idle_cyc;
  logic [`HELP_W-1:0] next_low_cyc;
  logic [`HELP_W-1:0] next_ext_cyc;
  logic [`HELP_W-1:0] next_idle_cyc;

  // Cycle counters that only the checks read.
  always_comb begin
    next_low_cyc  = (uv || reset1_n) ? '0 : low_cyc + 1'b1;
    next_ext_cyc  = (reset1_n && !reset2_n) ? ext_cyc + 1'b1 : '0;
    next_idle_cyc = (kick_edge || !reset1_n) ? '0 : idle_cyc + 1'b1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cyc  <= '0;
      ext_cyc  <= '0;
      idle_cyc <= '0;
    end else begin
      low_cyc  <= next_low_cyc;
      ext_cyc  <= next_ext_cyc;
      idle_cyc <= next_idle_cyc;
    end
  end

  property p_uv_low;
    @(posedge clk) disable iff (rst)
    uv |=> (!reset1_n && !reset2_n);
  endproperty
  a_uv_low: assert property (p_uv_low)
    else $error("Outputs not low during undervoltage.");

  property p_uv_hold;
    @(posedge clk) disable iff (rst)
    $fell(uv) |-> !reset1_n ##1 !reset1_n;
  endproperty
  a_uv_hold: assert property (p_uv_hold)
    else $error("Primary released as supply recovered.");

  property p_hold1_len;
    @(posedge clk) disable iff (rst)
    $rose(reset1_n) |-> ($past(low_cyc) + 1 >= HOLD1_CYC - 1)
                     && ($past(low_cyc) <= HOLD1_CYC + 1);
  endproperty
  a_hold1_len: assert property (p_hold1_len)
    else $error("Primary hold time wrong.");

  property p_hold2_len;
    @(posedge clk) disable iff (rst)
    $rose(reset2_n) |-> ($past(ext_cyc) + 1 >= HOLD2_CYC - 1)
                     && ($past(ext_cyc) <= HOLD2_CYC + 1);
  endproperty
  a_hold2_len: assert property (p_hold2_len)
    else $error("Secondary extension time wrong.");

  property p_same_edge;
    @(posedge clk) disable iff (rst)
    $fell(reset1_n) |-> !reset2_n;
  endproperty
  a_same_edge: assert property (p_same_edge)
    else $error("Secondary not asserted with primary.");

  property p_wd_late;
    @(posedge clk) disable iff (rst)
    ($fell(reset1_n) && !$past(uv)) |->
      $past(idle_cyc) + 1 >= (int'(period_ticks($past(sel))) - 1) * TICK_CYCLES;
  endproperty
  a_wd_late: assert property (p_wd_late)
    else $error("Watchdog reset came before the period.");

  property p_kick_clear;
    @(posedge clk) disable iff (rst)
    (kick_edge && reset1_n && !uv) |=> cnt == '0;
  endproperty
  a_kick_clear: assert property (p_kick_clear)
    else $error("Kick edge did not restart count.");

  property p_rel_clear;
    @(posedge clk) disable iff (rst)
    $rose(reset1_n) |-> cnt == '0 ##1 (cnt <= 1);
  endproperty
  a_rel_clear: assert property (p_rel_clear)
    else $error("Count not restarted at release.");

  property p_float;
    @(posedge clk) disable iff (rst)
    (wd_off && !uv && state != ST_HOLD) |=> reset1_n;
  endproperty
  a_float: assert property (p_float)
    else $error("Reset while watchdog disabled.");

  property p_uv_restart;
    @(posedge clk) disable iff (rst)
    uv |=> (cnt == '0 && pre == '0);
  endproperty
  a_uv_restart: assert property (p_uv_restart)
    else $error("Hold not restarted by undervoltage.");

  c_power_on: cover property (@(posedge clk) disable iff (rst)
    $rose(reset2_n));
  c_wd_reset: cover property (@(posedge clk) disable iff (rst)
    $fell(reset1_n) && !$past(uv));
  c_uv_in_ext: cover property (@(posedge clk) disable iff (rst)
    state == ST_EXT && uv);
  c_kick_restart: cover property (@(posedge clk) disable iff (rst)
    kick_edge && reset1_n && !uv);
  c_float_run: cover property (@(posedge clk) disable iff (rst)
    wd_off && reset2_n);

endmodule

`default_nettype wire

// ### kick_partner.sv
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Processor side of the kick pin
// ----------------------------------------
module kick_partner (
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic [15:0] gap,
  output var  logic        kick_input
);
  logic [15:0] cnt;

  // Toggle every gap cycles while running; a stalled processor leaves the pin still.
  // One process owns both variables, so each has a single driver.
  initial begin
    kick_input = 1'b0;
    cnt = 16'h0000;
    forever begin
      @(posedge clk);
      if (run && cnt + 16'h0001 >= gap) begin
        kick_input <= #1 ~kick_input;
        cnt <= #1 16'h0000;
      end else begin
        cnt <= #1 (run ? cnt + 16'h0001 : 16'h0000);
      end
    end
  end
endmodule
`default_nettype wire

// ### supply_watchdog_reset_gen_bench.sv
`timescale 1ns/1ns
`default_nettype none

module supply_watchdog_reset_gen_bench;
  localparam int T = 10;
  localparam int HOLD1 = 200 * T; // 50 ms in quarter-millisecond ticks.
  localparam int HOLD2 = 40 * T;  // 10 ms extension.
  localparam int LIMIT = 60000;

  logic        clk, rst, low, floating, sel_hi, sel_lo, run, kick, r1_n, r2_n;
  logic [15:0] gap;
  int          num_errors = 0;
  int          check_count = 0;
  int          cycles = 0;

  supply_watchdog_reset_gen #(.TICK_CYCLES(T)) dut (
    .clk(clk), .rst(rst), .monitored_supply_low(low), .kick_input(kick),
    .kick_floating(floating), .period_sel_hi(sel_hi), .period_sel_lo(sel_lo),
    .reset1_n(r1_n), .reset2_n(r2_n));

  kick_partner proc (.clk(clk), .run(run), .gap(gap), .kick_input(kick));

  // ----------------------------------------
  // Clock, watchdog on the run, reporting
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // A hang in any wait is cut short here rather than stalling the run.
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      num_errors++;
      $display("CHECK FAILED run length expected below %0d seen %0d", LIMIT, cycles);
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("Checks made %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check_range(string name, int lo, int hi, int seen);
    check_count++;
    if (seen < lo || seen > hi) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", name, lo, hi, seen);
    end
  endtask

  task automatic check_bit(string name, logic exp, logic seen);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, seen);
    end
  endtask

  // Counts cycles until the chosen output reaches val, sampling after each edge settles.
  task automatic wait_out(input bit second, input logic val, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (((second ? r2_n : r1_n) !== val) && n < 3000);
  endtask

  // Counts samples where the primary reset leaves the wanted level.
  task automatic stay(int n, logic want, string name);
    int bad;
    bad = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (r1_n !== want) bad++;
    end
    check_range(name, 0, 0, bad);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_power_on();
    int n;
    wait_out(0, 1'b1, n);
    check_range("power-on hold", HOLD1 - 2, HOLD1 + 8, n);
    check_bit("reset2_n at primary release", 1'b0, r2_n);
    wait_out(1, 1'b1, n);
    check_range("secondary extension", HOLD2 - 2, HOLD2 + 2, n);
  endtask

  // A second dip part way through the hold must restart the full 50 ms.
  task automatic t_dip();
    int n;
    low = 1'b1;
    wait_out(0, 1'b0, n);
    check_range("dip response", 3, 5, n);
    check_bit("reset2_n with reset1_n", 1'b0, r2_n);
    stay(3000, 1'b0, "held under low supply");
    low = 1'b0;
    stay(1000, 1'b0, "hold before second dip");
    low = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    low = 1'b0;
    wait_out(0, 1'b1, n);
    check_range("hold after second dip", HOLD1, HOLD1 + 8, n);
    wait_out(1, 1'b1, n);
    check_range("extension after second dip", HOLD2 - 2, HOLD2 + 2, n);
  endtask

  task automatic t_keepalive();
    {sel_hi, sel_lo} = 2'b00;
    stay(3000, 1'b1, "kicked at shortest period");
  endtask

  task automatic t_float();
    int n;
    run = 1'b0;
    floating = 1'b1;
    stay(3000, 1'b1, "no timeout while floating");
    low = 1'b1;
    wait_out(0, 1'b0, n);
    check_range("dip while floating", 3, 5, n);
    low = 1'b0;
    wait_out(0, 1'b1, n);
    floating = 1'b0;
  endtask

  // Every select code; short periods expire inside the secondary extension.
  task automatic t_timeouts();
    int per[4] = '{3, 6, 50, 100};
    int n;
    for (int c = 0; c < 4; c++) begin
      wait_out(0, 1'b0, n);
      {sel_hi, sel_lo} = c[1:0];
      wait_out(0, 1'b1, n);
      check_range("hold after expiry", HOLD1 - 2, HOLD1 + 2, n);
      wait_out(0, 1'b0, n);
      check_range("kick timeout", (per[c] - 1) * T - 1, per[c] * T + 2, n);
      check_bit("reset2_n on expiry", 1'b0, r2_n);
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    low = 1'b0;
    floating = 1'b0;
    sel_hi = 1'b1;
    sel_lo = 1'b1;
    run = 1'b1;
    gap = 16'h000F;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    check_bit("reset2_n after rst", 1'b0, r2_n);
    t_power_on();
    t_dip();
    t_keepalive();
    t_float();
    t_timeouts();
    give_verdict();
  end
endmodule
`default_nettype wire
